// ==== ivfm_pkg.sv ====
// shared constants and carriers for the input voltage fault manager
package ivfm_pkg;

	// ==========================================================
	// command codes
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_OV_RESPONSE = 8'h56;
	localparam logic [7:0] CMD_UVW_LIMIT = 8'h58;
	localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
	localparam logic [7:0] CMD_STATUS_INPUT = 8'h7C;
	localparam logic [7:0] CMD_STATUS_CML = 8'h7E;

	// ==========================================================
	// overvoltage response byte layout
	localparam int ACT_LSB = 6;
	localparam int RETRY_LSB = 3;
	localparam int DLY_LSB = 0;
	localparam logic [1:0] ACT_IGNORE = 2'h0;
	localparam logic [1:0] ACT_DELAYED = 2'h1;
	localparam logic [1:0] ACT_IMMEDIATE = 2'h2;
	localparam logic [1:0] ACT_BAD = 2'h3;
	localparam logic [2:0] RETRY_LATCH = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	localparam logic [7:0] OV_RESPONSE_RST = 8'h80;

	// shutdown delays in switching periods
	localparam logic [3:0] DLY_SHORT = 4'h3;
	localparam logic [3:0] DLY_MID = 4'h5;
	localparam logic [3:0] DLY_LONG = 4'h9;

	// ==========================================================
	// warning limit word layout, linear format
	localparam int EXP_LSB = 11;
	localparam logic [4:0] UVW_EXP_RST = 5'h1E;
	localparam logic [10:0] UVW_MAN_RST = 11'h00A;
	localparam int FIX_FRAC = 10;
	localparam logic signed [47:0] UVW_MIN_FIX = 48'sh0000_0000_1400;
	localparam logic signed [47:0] UVW_MAX_FIX = 48'sh0000_0000_5800;

	// ==========================================================
	// status bit positions
	localparam int SB_CML = 1;
	localparam int SB_NONE = 0;
	localparam int SW_INPUT = 13;
	localparam int SI_VIN_OV = 7;
	localparam int SI_INPUT_LOW_WARNING_BIT = 5;
	localparam int CML_BAD_CMD = 7;
	localparam int CML_BAD_DATA = 6;

	// ==========================================================
	// carriers across the link crossing
	typedef struct packed {
		logic write;
		logic [7:0] code;
		logic [15:0] wdata;
	} ivfm_req_t;

	typedef struct packed {
		logic [15:0] rdata;
		logic rejected;
	} ivfm_rsp_t;

	typedef enum logic [4:0] {
		ST_OFF = 5'h01,
		ST_RUN = 5'h02,
		ST_DELAY = 5'h04,
		ST_RESTART_WAIT_PERIOD = 5'h08,
		ST_LATCHED = 5'h10
	} ivfm_state_t;

endpackage

// ==== ivfm_top.sv ====
// input voltage fault manager: response state machine, limits, status and command port
//
// What this block does
// - ignore action keeps regulating during overvoltage
// - delayed action stops after delay if fault persists
// - immediate action stops switching at once
// - action value 11b write is invalid data
// - retry zero latches off after shutdown
// - retry 1-6 hiccups then latches after budget
// - restarts during overvoltage still count as attempts
// - retry seven hiccups and retries without limit
// - delay 0-1: three cycles, one rise restart_wait_period
// - delay 2-4: five cycles, value times rise
// - delay 5-7: nine cycles, value times rise
// - ignore action refuses start while fault present
// - bad writes rejected, status set, host alerted
// - warn when input reaches warning limit
// - warning sets byte, word, input bits, alert
// - limit defaults 2.5 V, accepts 5-22 V
// - once above 5 V, never below 5 V
// - limit word: exponent 15:11, mantissa 10:0
// - restart_wait_period scales from programmed soft-start rise time
// - overvoltage sets input, catch-all bits and alerts
`timescale 1ns/1ps

module ivfm_top #(
	parameter int RISE_W = 24
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic link_clk_i,
	input wire logic cmd_valid_i,
	input wire ivfm_pkg::ivfm_req_t cmd_req_i,
	output logic cmd_ready_o,
	output logic cmd_done_o,
	output ivfm_pkg::ivfm_rsp_t cmd_rsp_o,
	input wire logic converter_enable_i,
	input wire logic input_overvoltage_fault_i,
	input wire logic pwm_tick_i,
	input wire logic startup_ok_i,
	input wire logic [15:0] power_stage_input_i,
	input wire logic [RISE_W-1:0] soft_start_rise_time_i,
	output logic switching_en_o,
	output logic latched_off_o,
	output logic alert_n_o,
	output logic [2:0] attempts_o
);

	// ==========================================================
	// parameter check
	if (RISE_W < 2 || RISE_W > 32)
	begin : g_bad_width
		$error("ivfm_top: RISE_W must lie between 2 and 32");
	end

	// ==========================================================
	// functions
	function automatic logic signed [47:0] lin_to_fix(input logic [15:0] w);
		logic signed [47:0] m;
		int sh;
		m = {{37{w[10]}}, w[10:0]};
		sh = int'($signed(w[15:ivfm_pkg::EXP_LSB])) + ivfm_pkg::FIX_FRAC;
		if (sh >= 0)
			lin_to_fix = m <<< sh;
		else
			lin_to_fix = m >>> (-sh);
	endfunction

	function automatic logic [3:0] shut_delay(input logic [2:0] dly);
		if (dly <= 3'h1)
			shut_delay = ivfm_pkg::DLY_SHORT;
		else if (dly <= 3'h4)
			shut_delay = ivfm_pkg::DLY_MID;
		else
			shut_delay = ivfm_pkg::DLY_LONG;
	endfunction

	function automatic ivfm_pkg::ivfm_state_t after_shutdown(input logic [2:0] retry, input logic [2:0] used);
		if (retry == ivfm_pkg::RETRY_LATCH)
			after_shutdown = ivfm_pkg::ST_LATCHED;
		else if (retry == ivfm_pkg::RETRY_FOREVER || used < retry)
			after_shutdown = ivfm_pkg::ST_RESTART_WAIT_PERIOD;
		else
			after_shutdown = ivfm_pkg::ST_LATCHED;
	endfunction

	// ==========================================================
	// reset release, one copy per domain
	logic rst_s1_q;
	logic rst_n;
	logic lrst_s1_q;
	logic lrst_n;

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	always_ff @(posedge link_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			lrst_s1_q <= 1'b0;
			lrst_n <= 1'b0;
		end
		else
		begin
			lrst_s1_q <= 1'b1;
			lrst_n <= lrst_s1_q;
		end
	end

	// ==========================================================
	// link side: hold request, toggle, wait for answer toggle
	ivfm_pkg::ivfm_req_t req_hold_q;
	ivfm_pkg::ivfm_rsp_t rsp_hold_q;
	logic req_tgl_q;
	logic ack_tgl_q;
	logic ack_s1_q;
	logic ack_s2_q;
	logic ack_s3_q;

	always_ff @(posedge link_clk_i or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			req_hold_q <= '0;
			req_tgl_q <= 1'b0;
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			ack_s3_q <= 1'b0;
			cmd_ready_o <= 1'b0;
			cmd_done_o <= 1'b0;
			cmd_rsp_o <= '0;
		end
		else
		begin
			ack_s1_q <= ack_tgl_q;
			ack_s2_q <= ack_s1_q;
			ack_s3_q <= ack_s2_q;
			cmd_done_o <= 1'b0;
			if (ack_s2_q != ack_s3_q)
			begin
				cmd_rsp_o <= rsp_hold_q;
				cmd_done_o <= 1'b1;
				cmd_ready_o <= 1'b1;
			end
			else if (cmd_valid_i && cmd_ready_o)
			begin
				req_hold_q <= cmd_req_i;
				req_tgl_q <= ~req_tgl_q;
				cmd_ready_o <= 1'b0;
			end
			else if (req_tgl_q == ack_s3_q && ack_s2_q == ack_s3_q)
			begin
				cmd_ready_o <= 1'b1;
			end
		end
	end

	// ==========================================================
	// core side: request detection and input synchronisers
	logic req_s1_q;
	logic req_s2_q;
	logic req_s3_q;
	logic ovf_s1_q;
	logic ovf_s;
	logic en_s1_q;
	logic en_s;
	logic req_new;

	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
			ovf_s1_q <= 1'b0;
			ovf_s <= 1'b0;
			en_s1_q <= 1'b0;
			en_s <= 1'b0;
		end
		else
		begin
			req_s1_q <= req_tgl_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
			ovf_s1_q <= input_overvoltage_fault_i;
			ovf_s <= ovf_s1_q;
			en_s1_q <= converter_enable_i;
			en_s <= en_s1_q;
		end
	end

	assign req_new = req_s2_q != req_s3_q;

	// ==========================================================
	// command decode and register writes
	logic [7:0] ov_resp_q;
	logic [15:0] uvw_limit_q;
	logic [7:0] stat_in_q;
	logic [7:0] cml_q;
	logic bad_cmd;
	logic bad_data;
	logic clear_req;
	logic signed [47:0] wr_fix;
	logic [15:0] rd_data;
	logic [7:0] stat_byte;

	assign wr_fix = lin_to_fix(req_hold_q.wdata);
	assign stat_byte = {6'h00, |cml_q, |stat_in_q};

	always_comb
	begin
		bad_cmd = 1'b0;
		bad_data = 1'b0;
		clear_req = 1'b0;
		rd_data = 16'h0000;
		case (req_hold_q.code)
			ivfm_pkg::CMD_OV_RESPONSE:
			begin
				rd_data = {8'h00, ov_resp_q};
				bad_data = req_hold_q.write && req_hold_q.wdata[ivfm_pkg::ACT_LSB+:2] == ivfm_pkg::ACT_BAD;
			end
			ivfm_pkg::CMD_UVW_LIMIT:
			begin
				rd_data = uvw_limit_q;
				// the floor of 5 V also keeps a raised limit from dropping below 5 V
				bad_data = req_hold_q.write && (wr_fix < ivfm_pkg::UVW_MIN_FIX
					|| wr_fix > ivfm_pkg::UVW_MAX_FIX);
			end
			ivfm_pkg::CMD_STATUS_BYTE:
			begin
				rd_data = {8'h00, stat_byte};
				bad_cmd = req_hold_q.write;
			end
			ivfm_pkg::CMD_STATUS_WORD:
			begin
				rd_data = {8'h00, stat_byte};
				rd_data[ivfm_pkg::SW_INPUT] = |stat_in_q;
				bad_cmd = req_hold_q.write;
			end
			ivfm_pkg::CMD_STATUS_INPUT:
			begin
				rd_data = {8'h00, stat_in_q};
				bad_cmd = req_hold_q.write;
			end
			ivfm_pkg::CMD_STATUS_CML:
			begin
				rd_data = {8'h00, cml_q};
				bad_cmd = req_hold_q.write;
			end
			ivfm_pkg::CMD_CLEAR_FAULTS:
			begin
				clear_req = req_hold_q.write;
				bad_cmd = !req_hold_q.write;
			end
			default:
			begin
				bad_cmd = 1'b1;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ov_resp_q <= ivfm_pkg::OV_RESPONSE_RST;
			uvw_limit_q <= {ivfm_pkg::UVW_EXP_RST, ivfm_pkg::UVW_MAN_RST};
		end
		else if (req_new && req_hold_q.write && !bad_data && !bad_cmd)
		begin
			if (req_hold_q.code == ivfm_pkg::CMD_OV_RESPONSE)
				ov_resp_q <= req_hold_q.wdata[7:0];
			if (req_hold_q.code == ivfm_pkg::CMD_UVW_LIMIT)
				uvw_limit_q <= req_hold_q.wdata;
		end
	end

	// answer word and answer toggle
	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rsp_hold_q <= '0;
			ack_tgl_q <= 1'b0;
		end
		else if (req_new)
		begin
			rsp_hold_q.rdata <= req_hold_q.write ? 16'h0000 : rd_data;
			rsp_hold_q.rejected <= bad_cmd || bad_data;
			ack_tgl_q <= ~ack_tgl_q;
		end
	end

	// ==========================================================
	// status bits: a set in the clearing cycle wins
	logic uvw_now;
	logic [7:0] in_set;
	logic [7:0] cml_set;

	assign uvw_now = lin_to_fix(power_stage_input_i) <= lin_to_fix(uvw_limit_q);

	always_comb
	begin
		in_set = 8'h00;
		cml_set = 8'h00;
		in_set[ivfm_pkg::SI_VIN_OV] = ovf_s;
		in_set[ivfm_pkg::SI_INPUT_LOW_WARNING_BIT] = uvw_now;
		cml_set[ivfm_pkg::CML_BAD_CMD] = req_new && bad_cmd;
		cml_set[ivfm_pkg::CML_BAD_DATA] = req_new && bad_data;
	end

	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stat_in_q <= 8'h00;
			cml_q <= 8'h00;
			alert_n_o <= 1'b1;
		end
		else
		begin
			stat_in_q <= (req_new && clear_req ? 8'h00 : stat_in_q) | in_set;
			cml_q <= (req_new && clear_req ? 8'h00 : cml_q) | cml_set;
			alert_n_o <= ~(|in_set | |cml_set | (|stat_in_q & !(req_new && clear_req))
				| (|cml_q & !(req_new && clear_req)));
		end
	end

	// ==========================================================
	// fault response state machine
	ivfm_pkg::ivfm_state_t st_q;
	ivfm_pkg::ivfm_state_t st_d;
	logic [1:0] act;
	logic [2:0] retry;
	logic [2:0] dly;
	logic [3:0] dly_cnt_q;
	logic [RISE_W-1:0] rise_cnt_q;
	logic [2:0] mult_cnt_q;
	logic [2:0] hic_mult;
	logic [RISE_W-1:0] rise_last;
	logic hic_end;
	logic dly_end;
	logic [2:0] used_q;

	assign act = ov_resp_q[ivfm_pkg::ACT_LSB+:2];
	assign retry = ov_resp_q[ivfm_pkg::RETRY_LSB+:3];
	assign dly = ov_resp_q[ivfm_pkg::DLY_LSB+:3];
	assign hic_mult = (dly <= 3'h1) ? 3'h1 : dly;
	assign rise_last = (soft_start_rise_time_i == '0) ? '0 : soft_start_rise_time_i - 1'b1;
	assign hic_end = st_q == ivfm_pkg::ST_RESTART_WAIT_PERIOD && rise_cnt_q == rise_last && mult_cnt_q == hic_mult - 3'h1;
	assign dly_end = pwm_tick_i && dly_cnt_q == shut_delay(dly) - 4'h1;
	assign attempts_o = used_q;

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			ivfm_pkg::ST_OFF:
				if (en_s && !ovf_s)
					st_d = ivfm_pkg::ST_RUN;
			ivfm_pkg::ST_RUN:
				if (ovf_s && act == ivfm_pkg::ACT_IMMEDIATE)
					st_d = after_shutdown(retry, used_q);
				else if (ovf_s && act == ivfm_pkg::ACT_DELAYED)
					st_d = ivfm_pkg::ST_DELAY;
			ivfm_pkg::ST_DELAY:
				if (!ovf_s)
					st_d = ivfm_pkg::ST_RUN;
				else if (dly_end)
					st_d = after_shutdown(retry, used_q);
			ivfm_pkg::ST_RESTART_WAIT_PERIOD:
				if (hic_end)
					st_d = ovf_s ? after_shutdown(retry, used_q + 3'h1) : ivfm_pkg::ST_RUN;
			ivfm_pkg::ST_LATCHED:
				st_d = ivfm_pkg::ST_LATCHED;
			default:
				st_d = ivfm_pkg::ST_OFF;
		endcase
		if (!en_s)
			st_d = ivfm_pkg::ST_OFF;
	end

	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= ivfm_pkg::ST_OFF;
			switching_en_o <= 1'b0;
			latched_off_o <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			switching_en_o <= st_d == ivfm_pkg::ST_RUN || st_d == ivfm_pkg::ST_DELAY;
			latched_off_o <= st_d == ivfm_pkg::ST_LATCHED;
		end
	end

	// delay and restart_wait_period timers
	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dly_cnt_q <= 4'h0;
			rise_cnt_q <= '0;
			mult_cnt_q <= 3'h0;
		end
		else
		begin
			if (st_q != ivfm_pkg::ST_DELAY)
				dly_cnt_q <= 4'h0;
			else if (pwm_tick_i)
				dly_cnt_q <= dly_cnt_q + 4'h1;
			if (st_q != ivfm_pkg::ST_RESTART_WAIT_PERIOD || hic_end)
			begin
				rise_cnt_q <= '0;
				mult_cnt_q <= 3'h0;
			end
			else if (rise_cnt_q == rise_last)
			begin
				rise_cnt_q <= '0;
				mult_cnt_q <= mult_cnt_q + 3'h1;
			end
			else
				rise_cnt_q <= rise_cnt_q + 1'b1;
		end
	end

	// restart attempts used
	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			used_q <= 3'h0;
		else if (!en_s || (startup_ok_i && st_q == ivfm_pkg::ST_RUN))
			used_q <= 3'h0;
		else if (hic_end && used_q != 3'h7)
			used_q <= used_q + 3'h1;
	end

	// ==========================================================
	// checks
	ignore_keeps_running_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		st_q == ivfm_pkg::ST_RUN && en_s && act == ivfm_pkg::ACT_IGNORE |=> st_q == ivfm_pkg::ST_RUN && switching_en_o)
		else $error("ignore action left regulation");
	delayed_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		st_q == ivfm_pkg::ST_DELAY && en_s && ovf_s && dly_end |=> st_q inside {ivfm_pkg::ST_RESTART_WAIT_PERIOD, ivfm_pkg::ST_LATCHED})
		else $error("delayed shutdown missed");
	immediate_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		st_q == ivfm_pkg::ST_RUN && en_s && ovf_s && act == ivfm_pkg::ACT_IMMEDIATE |=> !switching_en_o)
		else $error("immediate shutdown missed");
	bad_action_kept_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		req_new && req_hold_q.write && req_hold_q.code == ivfm_pkg::CMD_OV_RESPONSE
		&& req_hold_q.wdata[7:6] == 2'h3 |=> $stable(ov_resp_q) && cml_q[ivfm_pkg::CML_BAD_DATA])
		else $error("invalid action accepted");
	latch_no_retry_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		st_q == ivfm_pkg::ST_RUN && en_s && ovf_s && act == ivfm_pkg::ACT_IMMEDIATE && retry == 3'h0
		|=> st_q == ivfm_pkg::ST_LATCHED)
		else $error("retry zero did not latch");
	attempt_counted_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		hic_end && en_s && used_q < 3'h6 && !startup_ok_i |=> used_q == $past(used_q) + 3'h1)
		else $error("restart attempt not counted");
	refuse_start_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		st_q == ivfm_pkg::ST_OFF && ovf_s |=> st_q == ivfm_pkg::ST_OFF)
		else $error("started during overvoltage");
	warn_flags_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		uvw_now |=> stat_in_q[ivfm_pkg::SI_INPUT_LOW_WARNING_BIT] && !alert_n_o)
		else $error("undervoltage warning not flagged");
	ov_flags_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		ovf_s |=> stat_in_q[ivfm_pkg::SI_VIN_OV] && !alert_n_o)
		else $error("overvoltage not flagged");
	off_clears_count_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		!en_s |=> used_q == 3'h0 && !switching_en_o)
		else $error("attempt count kept while off");

endmodule // ivfm_top

// ==== ivfm_host_model.sv ====
// host-side model of the command port master
`timescale 1ns/1ps

module ivfm_host_model (
	input wire logic link_clk_i,
	input wire logic cmd_ready_i,
	input wire logic cmd_done_i,
	input wire ivfm_pkg::ivfm_rsp_t cmd_rsp_i,
	output logic cmd_valid_o,
	output ivfm_pkg::ivfm_req_t cmd_req_o
);
	initial
	begin
		cmd_valid_o = 1'b0;
		cmd_req_o = '0;
	end

	// ==========================================================
	// one request outstanding, held for one link cycle once ready is seen; released fields are inverted
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
		output ivfm_pkg::ivfm_rsp_t rsp);
		int n;
		n = 0;
		@(posedge link_clk_i);
		while (cmd_ready_i !== 1'b1 && n < 100)
		begin
			@(posedge link_clk_i);
			n++;
		end
		#1;
		cmd_valid_o = 1'b1;
		cmd_req_o = {wr, code, wd};
		@(posedge link_clk_i);
		#1;
		cmd_valid_o = 1'b0;
		cmd_req_o = ~cmd_req_o;
		n = 0;
		do
		begin
			@(posedge link_clk_i);
			n++;
		end
		while (cmd_done_i !== 1'b1 && n < 100);
		rsp = cmd_rsp_i;
		// no answer: unknown response so every compare of it fails
		if (cmd_done_i !== 1'b1)
			rsp = 'x;
	endtask
endmodule // ivfm_host_model

// ==== tb_ivfm_top.sv ====
// self-checking bench for the input voltage fault manager
`timescale 1ns/1ps

module tb_ivfm_top;
	localparam int RISE = 8;
	logic core_clk_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic cmd_valid_i;
	ivfm_pkg::ivfm_req_t cmd_req_i;
	logic cmd_ready_o;
	logic cmd_done_o;
	ivfm_pkg::ivfm_rsp_t cmd_rsp_o;
	logic converter_enable_i = 1'b0;
	logic input_overvoltage_fault_i = 1'b0;
	logic pwm_tick_i = 1'b0;
	logic startup_ok_i = 1'b0;
	logic [15:0] power_stage_input_i = 16'hF028;
	logic [23:0] soft_start_rise_time_i = 24'h000008;
	logic switching_en_o;
	logic latched_off_o;
	logic alert_n_o;
	logic [2:0] attempts_o;
	int mismatches = 0;
	int checks_done = 0;
	int tick_cnt = 0;
	ivfm_pkg::ivfm_rsp_t rsp;

	always #25 core_clk_i = ~core_clk_i;

	initial
	begin
		#7;
		forever #24 link_clk_i = ~link_clk_i;
	end

	// one switching period every eight core cycles
	always @(posedge core_clk_i)
	begin
		#1;
		tick_cnt++;
		pwm_tick_i = (tick_cnt % 8 == 0);
	end

	ivfm_top dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .link_clk_i(link_clk_i),
		.cmd_valid_i(cmd_valid_i), .cmd_req_i(cmd_req_i), .cmd_ready_o(cmd_ready_o),
		.cmd_done_o(cmd_done_o), .cmd_rsp_o(cmd_rsp_o), .converter_enable_i(converter_enable_i),
		.input_overvoltage_fault_i(input_overvoltage_fault_i), .pwm_tick_i(pwm_tick_i),
		.startup_ok_i(startup_ok_i), .power_stage_input_i(power_stage_input_i),
		.soft_start_rise_time_i(soft_start_rise_time_i), .switching_en_o(switching_en_o),
		.latched_off_o(latched_off_o), .alert_n_o(alert_n_o), .attempts_o(attempts_o));

	ivfm_host_model host (.link_clk_i(link_clk_i), .cmd_ready_i(cmd_ready_o), .cmd_done_i(cmd_done_o),
		.cmd_rsp_i(cmd_rsp_o), .cmd_valid_o(cmd_valid_i), .cmd_req_o(cmd_req_i));

	// ==========================================================
	// helpers
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cb(input string what, input logic exp, input logic got);
		chk(what, {15'h0000, exp}, {15'h0000, got});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] wd, input logic rej);
		host.xfer(wr, code, wd, rsp);
		cb($sformatf("rejected %h", code), rej, rsp.rejected);
	endtask

	task automatic rd(input logic [7:0] code, input logic [15:0] mask, input logic [15:0] exp);
		cmd(1'b0, code, 16'h0000, 1'b0);
		chk($sformatf("read %h", code), exp, rsp.rdata & mask);
	endtask

	task automatic wait_sw(input logic v, input int lim, output int n);
		n = 0;
		while (switching_en_o !== v && n < lim)
		begin
			cyc(1);
			n++;
		end
	endtask

	// start-up with the input below the fault level
	task automatic start_conv();
		int n;
		cyc(1);
		converter_enable_i = 1'b1;
		wait_sw(1'b1, 40, n);
		cb("switching on", 1'b1, switching_en_o);
		startup_ok_i = 1'b1;
		cyc(1);
		startup_ok_i = 1'b0;
		cyc(2);
	endtask

	task automatic stop_conv();
		converter_enable_i = 1'b0;
		input_overvoltage_fault_i = 1'b0;
		cyc(8);
		cb("latched", 1'b0, latched_off_o);
		chk("attempts", 16'h0000, {13'h0000, attempts_o});
	endtask

	// ==========================================================
	// scenarios
	task automatic t_regs();
		rd(ivfm_pkg::CMD_OV_RESPONSE, 16'hFFFF, {8'h00, ivfm_pkg::OV_RESPONSE_RST});
		rd(ivfm_pkg::CMD_UVW_LIMIT, 16'hFFFF, 16'hF00A);
		cmd(1'b1, ivfm_pkg::CMD_OV_RESPONSE, 16'h00C0, 1'b1);
		rd(ivfm_pkg::CMD_OV_RESPONSE, 16'hFFFF, 16'h0080);
		rd(ivfm_pkg::CMD_STATUS_CML, 16'h0040, 16'h0040);
		cyc(4);
		cb("alert", 1'b0, alert_n_o);
		cmd(1'b1, ivfm_pkg::CMD_UVW_LIMIT, 16'hF010, 1'b1);
		cmd(1'b1, ivfm_pkg::CMD_UVW_LIMIT, 16'hF05C, 1'b1);
		cmd(1'b1, ivfm_pkg::CMD_UVW_LIMIT, 16'hF058, 1'b0);
		cmd(1'b1, ivfm_pkg::CMD_UVW_LIMIT, 16'hF014, 1'b0);
		cmd(1'b1, ivfm_pkg::CMD_UVW_LIMIT, 16'hF018, 1'b0);
		cmd(1'b1, ivfm_pkg::CMD_UVW_LIMIT, 16'hF012, 1'b1);
		rd(ivfm_pkg::CMD_UVW_LIMIT, 16'hFFFF, 16'hF018);
		cmd(1'b0, ivfm_pkg::CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
		rd(ivfm_pkg::CMD_STATUS_CML, 16'h0080, 16'h0080);
		cmd(1'b1, ivfm_pkg::CMD_STATUS_BYTE, 16'h0000, 1'b1);
		cmd(1'b0, 8'h5A, 16'h0000, 1'b1);
		cmd(1'b1, ivfm_pkg::CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
		cyc(4);
		cb("alert", 1'b1, alert_n_o);
	endtask

	task automatic t_uv();
		cyc(1);
		power_stage_input_i = 16'hF010;
		cyc(6);
		rd(ivfm_pkg::CMD_STATUS_INPUT, 16'h00A0, 16'h0020);
		rd(ivfm_pkg::CMD_STATUS_WORD, 16'h2000, 16'h2000);
		rd(ivfm_pkg::CMD_STATUS_BYTE, 16'h0001, 16'h0001);
		cb("alert", 1'b0, alert_n_o);
		cyc(1);
		power_stage_input_i = 16'hF028;
		cyc(6);
		cmd(1'b1, ivfm_pkg::CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
		rd(ivfm_pkg::CMD_STATUS_INPUT, 16'hFFFF, 16'h0000);
	endtask

	task automatic t_ignore();
		cmd(1'b1, ivfm_pkg::CMD_OV_RESPONSE, 16'h0000, 1'b0);
		start_conv();
		input_overvoltage_fault_i = 1'b1;
		cyc(40);
		cb("switching", 1'b1, switching_en_o);
		rd(ivfm_pkg::CMD_STATUS_INPUT, 16'h0080, 16'h0080);
		rd(ivfm_pkg::CMD_STATUS_WORD, 16'h2000, 16'h2000);
		rd(ivfm_pkg::CMD_STATUS_BYTE, 16'h0001, 16'h0001);
		cb("alert", 1'b0, alert_n_o);
		cyc(1);
		converter_enable_i = 1'b0;
		cyc(6);
		converter_enable_i = 1'b1;
		cyc(40);
		cb("blocked start", 1'b0, switching_en_o);
		stop_conv();
	endtask

	task automatic t_delay();
		logic [2:0] dly [3] = '{3'h1, 3'h2, 3'h5};
		int ticks [3] = '{3, 5, 9};
		foreach (dly[i])
		begin
			cmd(1'b1, ivfm_pkg::CMD_OV_RESPONSE, {13'h0000, dly[i]} | 16'h0040, 1'b0);
			start_conv();
			@(posedge pwm_tick_i);
			input_overvoltage_fault_i = 1'b1;
			repeat (ticks[i] - 1) @(posedge pwm_tick_i);
			cyc(2);
			cb("delayed run", 1'b1, switching_en_o);
			@(posedge pwm_tick_i);
			cyc(4);
			cb("delayed stop", 1'b0, switching_en_o);
			cb("latched", 1'b1, latched_off_o);
			stop_conv();
		end
	endtask

	task automatic t_restart_wait_period();
		logic [2:0] dly [4] = '{3'h0, 3'h1, 3'h3, 3'h6};
		int mult [4] = '{1, 1, 3, 6};
		int gap [4];
		int n;
		foreach (dly[i])
		begin
			cmd(1'b1, ivfm_pkg::CMD_OV_RESPONSE, {13'h0000, dly[i]} | 16'h0088, 1'b0);
			start_conv();
			input_overvoltage_fault_i = 1'b1;
			wait_sw(1'b0, 8, n);
			cb("immediate stop", 1'b0, switching_en_o);
			input_overvoltage_fault_i = 1'b0;
			wait_sw(1'b1, 200, gap[i]);
			chk("attempts", 16'h0001, {13'h0000, attempts_o});
			chk("restart_wait_period", 16'(mult[i] * RISE), 16'(gap[i]));
			startup_ok_i = 1'b1;
			cyc(1);
			startup_ok_i = 1'b0;
			cyc(3);
			chk("attempts", 16'h0000, {13'h0000, attempts_o});
			stop_conv();
		end
	endtask

	task automatic t_budget();
		cmd(1'b1, ivfm_pkg::CMD_OV_RESPONSE, 16'h0090, 1'b0);
		start_conv();
		input_overvoltage_fault_i = 1'b1;
		cyc(100);
		chk("attempts", 16'h0002, {13'h0000, attempts_o});
		cb("latched", 1'b1, latched_off_o);
		input_overvoltage_fault_i = 1'b0;
		cyc(20);
		cb("stays off", 1'b0, switching_en_o);
		stop_conv();
	endtask

	task automatic t_forever();
		int n;
		cmd(1'b1, ivfm_pkg::CMD_OV_RESPONSE, 16'h00B8, 1'b0);
		start_conv();
		input_overvoltage_fault_i = 1'b1;
		cyc(200);
		chk("attempts", 16'h0007, {13'h0000, attempts_o});
		cb("latched", 1'b0, latched_off_o);
		input_overvoltage_fault_i = 1'b0;
		wait_sw(1'b1, 60, n);
		cb("restart", 1'b1, switching_en_o);
		stop_conv();
	endtask

	// ==========================================================
	// run control
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (4) @(posedge core_clk_i);
		#1;
		nrst_i = 1'b1;
		cyc(10);
		t_regs();
		t_uv();
		t_ignore();
		t_delay();
		t_restart_wait_period();
		t_budget();
		t_forever();
		complete_run();
	end

	initial
	begin
		#2000000;
		mismatches++;
		complete_run();
	end
endmodule // tb_ivfm_top
